// ### verilog/gdio_port.sv
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps

// Summary of operation
// RQ1: Direction bit one makes the pin an output, zero an input.
// RQ2: Pull-up on only for input pin with latch one and pull-ups not disabled.
// RQ3: Global pull-up disable turns every pull-up off regardless of pin settings.
// RQ4: Reset tri-states all pins at once, without needing a clock.
// RQ5: Output pin drives high for latch one, low for latch zero.
// RQ6: Writing one to an input register bit inverts that latch bit.
// RQ7: Separate latch, direction and input registers; input register read-only.
// RQ8: Single-bit set and clear of direction and latch leave other pins alone.
// RQ9: Input register reads the pin level whatever the direction.
// RQ10: Falling-edge capture stage, then input register loads on the rising edge.
// RQ11: External pin change reaches input register after half to one-and-half periods.
// RQ12: Written output level reaches input register one period after the write.
// RQ13: Software waits one cycle between a latch write and reading it back.
// RQ14: Tri-state to output high passes through pull-up input or output low.
// RQ15: Software uses tri-state or output high between pull-up input and output low.
// RQ16: Pins used by other functions leave remaining pins fully general purpose.
// RQ17: Deep sleep clamps pin inputs low before capture, except interrupt pins.
// RQ18: Eight pins per port; direction and latch reset to zero.
module gdio_port #(
  parameter int unsigned PIN_COUNT = 8
) (
  // Clock, reset, enable
  input  wire logic                               clk,
  input  wire logic                               rst,
  input  wire logic                               ce,
  // AXI4-Lite write address
  input  wire logic                               s_axi_awvalid,
  output logic                                    s_axi_awready,
  input  wire logic [gdio_pkg::GDIO_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                         s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                               s_axi_wvalid,
  output logic                                    s_axi_wready,
  input  wire logic [gdio_pkg::GDIO_DATA_W-1:0]   s_axi_wdata,
  input  wire logic [gdio_pkg::GDIO_STRB_W-1:0]   s_axi_wstrb,
  // AXI4-Lite write response
  output logic                                    s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  output logic [1:0]                              s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                               s_axi_arvalid,
  output logic                                    s_axi_arready,
  input  wire logic [gdio_pkg::GDIO_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]                         s_axi_arprot,
  // AXI4-Lite read data
  output logic                                    s_axi_rvalid,
  input  wire logic                               s_axi_rready,
  output logic [gdio_pkg::GDIO_DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                              s_axi_rresp,
  // Sleep controller
  input  wire logic                               deep_sleep,
  input  wire logic [PIN_COUNT-1:0]               ext_int_enable,
  // Port pins
  input  wire logic [PIN_COUNT-1:0]               gpio_pin_in,
  output logic [PIN_COUNT-1:0]                    gpio_pin_out,
  output logic [PIN_COUNT-1:0]                    gpio_pin_oe,
  output logic [PIN_COUNT-1:0]                    gpio_pin_pullup
);
  import gdio_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [PIN_COUNT-1:0]         port_output_latch_register;
  logic [PIN_COUNT-1:0]         port_direction_register;
  logic [PIN_COUNT-1:0]         port_input_register;
  logic                         global_pullup_disable;
  logic [PIN_COUNT-1:0]         sync_capture;

  // Write channel holding state
  logic                         aw_held;
  logic [GDIO_ADDR_W-1:0]       aw_addr_q;
  logic                         w_held;
  logic [GDIO_DATA_W-1:0]       w_data_q;
  logic [GDIO_STRB_W-1:0]       w_strb_q;

  // Reset pattern for the per-pin registers
  localparam logic [PIN_COUNT-1:0] RST_DIR   = {PIN_COUNT{GDIO_RST_DIR_BIT}};
  localparam logic [PIN_COUNT-1:0] RST_LATCH = {PIN_COUNT{GDIO_RST_LATCH_BIT}};

  //////////////////////////////////////////////////////////////////////////////
  // Write channel handshakes

  wire                          aw_fire = s_axi_awvalid & s_axi_awready;
  wire                          w_fire  = s_axi_wvalid & s_axi_wready;
  wire                          have_aw = aw_held | aw_fire;
  wire                          have_w  = w_held | w_fire;
  // Address and data may arrive in either order; commit once both are here
  wire                          wr_go   = have_aw & have_w & ~s_axi_bvalid;
  wire [GDIO_ADDR_W-1:0]        wr_addr = aw_held ? aw_addr_q : s_axi_awaddr;
  wire [GDIO_DATA_W-1:0]        wr_data = w_held ? w_data_q : s_axi_wdata;
  wire [GDIO_STRB_W-1:0]        wr_strb = w_held ? w_strb_q : s_axi_wstrb;

  wire                          next_aw_held = have_aw & ~wr_go;
  wire                          next_w_held  = have_w & ~wr_go;
  wire                          next_bvalid  = wr_go | (s_axi_bvalid & ~s_axi_bready);

  //////////////////////////////////////////////////////////////////////////////
  // Write decode

  wire gdio_reg_t               wsel    = gdio_decode(wr_addr);
  // All pin fields live in byte lane 0; a write without it changes nothing
  wire                          wen     = wr_go & wr_strb[0];
  wire [PIN_COUNT-1:0]          wbits   = wr_data[PIN_COUNT-1:0];
  wire                          wr_bad  = (wsel == GDIO_REG_NONE);

  wire                          w_latch     = wen & (wsel == GDIO_REG_LATCH);
  wire                          w_dir       = wen & (wsel == GDIO_REG_DIR);
  wire                          w_input     = wen & (wsel == GDIO_REG_INPUT);
  wire                          w_ctrl      = wen & (wsel == GDIO_REG_CTRL);
  wire                          w_dir_set   = wen & (wsel == GDIO_REG_DIR_SET);
  wire                          w_dir_clr   = wen & (wsel == GDIO_REG_DIR_CLR);
  wire                          w_latch_set = wen & (wsel == GDIO_REG_LATCH_SET);
  wire                          w_latch_clr = wen & (wsel == GDIO_REG_LATCH_CLR);

  // Direction: whole-word write or masked set and clear
  wire [PIN_COUNT-1:0]          next_dir =
    w_dir     ? wbits :                                          // see RQ1
    w_dir_set ? (port_direction_register | wbits) :              // see RQ8
    w_dir_clr ? (port_direction_register & ~wbits) :             // see RQ8
    port_direction_register;

  // Latch: write, masked set and clear, or toggle through the input register
  wire [PIN_COUNT-1:0]          next_latch =
    w_latch     ? wbits :
    w_input     ? (port_output_latch_register ^ wbits) :         // see RQ6
    w_latch_set ? (port_output_latch_register | wbits) :         // see RQ8
    w_latch_clr ? (port_output_latch_register & ~wbits) :        // see RQ8
    port_output_latch_register;

  wire                          next_pud =
    w_ctrl ? wr_data[GDIO_CTRL_PUD_BIT] : global_pullup_disable;

  // Pull-up only on inputs with latch high while not globally disabled
  wire [PIN_COUNT-1:0]          next_pullup =
    ~next_dir & next_latch & {PIN_COUNT{~next_pud}};             // see RQ2, RQ3

  //////////////////////////////////////////////////////////////////////////////
  // Read decode

  wire                          ar_fire = s_axi_arvalid & s_axi_arready;
  wire                          next_rvalid = ar_fire | (s_axi_rvalid & ~s_axi_rready);
  wire gdio_reg_t               rsel    = gdio_decode(s_axi_araddr);
  wire                          clamp_on = deep_sleep;

  // Set and clear aliases read back the register they act on
  wire [PIN_COUNT-1:0]          rd_pins =
    (rsel == GDIO_REG_LATCH || rsel == GDIO_REG_LATCH_SET || rsel == GDIO_REG_LATCH_CLR)
      ? port_output_latch_register :
    (rsel == GDIO_REG_DIR || rsel == GDIO_REG_DIR_SET || rsel == GDIO_REG_DIR_CLR)
      ? port_direction_register :
    (rsel == GDIO_REG_INPUT) ? port_input_register :             // see RQ7, RQ9
    {PIN_COUNT{1'b0}};

  wire [GDIO_DATA_W-1:0]        rd_ctrl =
    (GDIO_DATA_W'(global_pullup_disable) << GDIO_CTRL_PUD_BIT) |
    (GDIO_DATA_W'(clamp_on) << GDIO_CTRL_CLAMP_BIT);

  wire [GDIO_DATA_W-1:0]        rd_word =
    (rsel == GDIO_REG_CTRL) ? rd_ctrl : GDIO_DATA_W'(rd_pins);
  wire [1:0]                    rd_resp =
    (rsel == GDIO_REG_NONE) ? GDIO_RESP_SLVERR : GDIO_RESP_OKAY;

  //////////////////////////////////////////////////////////////////////////////
  // Input path

  // Sleep clamp forces the input low ahead of capture; interrupt pins exempt
  wire [PIN_COUNT-1:0]          pin_gated =
    gpio_pin_in & ~({PIN_COUNT{clamp_on}} & ~ext_int_enable);    // see RQ17

  // Capture stage: acts like a latch open while clk is high, closed at the fall
  always_ff @(negedge clk or posedge rst) begin
    if (rst) begin
      sync_capture <= '0;
    end else if (ce) begin
      sync_capture <= pin_gated;                                 // see RQ10, RQ11
    end
  end

  // Input register takes the captured level on the next rising edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_input_register <= '0;
    end else if (ce) begin
      port_input_register <= sync_capture;                       // see RQ10, RQ12
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin control registers

  // Async reset clears direction, so every pin floats even without a clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_direction_register    <= RST_DIR;                     // see RQ4, RQ18
      port_output_latch_register <= RST_LATCH;                   // see RQ18
      global_pullup_disable      <= GDIO_RST_PUD;
    end else if (ce) begin
      port_direction_register    <= next_dir;
      port_output_latch_register <= next_latch;
      global_pullup_disable      <= next_pud;
    end
  end

  // Pin drivers are flops loaded from the same next values as the registers
  // Each pin is decided by its own bits and the global pull-up disable only, so neighbours never interfere
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gpio_pin_oe     <= RST_DIR;                                // see RQ4
      gpio_pin_out    <= RST_LATCH;
      gpio_pin_pullup <= '0;                                     // see RQ4
    end else if (ce) begin
      gpio_pin_oe     <= next_dir;                               // see RQ1, RQ16
      gpio_pin_out    <= next_latch;                             // see RQ5, RQ14
      gpio_pin_pullup <= next_pullup;                            // see RQ2, RQ3, RQ14
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel state

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held   <= 1'b0;
      aw_addr_q <= '0;
      w_held    <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end else if (ce) begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      if (aw_fire) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // Readies stay low while a word waits or a response is pending
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= GDIO_RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= ~next_aw_held & ~next_bvalid;
      s_axi_wready  <= ~next_w_held & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (wr_go) begin
        s_axi_bresp <= wr_bad ? GDIO_RESP_SLVERR : GDIO_RESP_OKAY;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  // One read in flight; data frozen until rready
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= GDIO_RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_fire) begin
        s_axi_rdata <= rd_word;                                  // see RQ9
        s_axi_rresp <= rd_resp;
      end
    end
  end

endmodule

// ### shared/gdio_pkg.sv
package gdio_pkg;

  // Register bus geometry
  localparam int unsigned GDIO_ADDR_W       = 5;
  localparam int unsigned GDIO_DATA_W       = 32;
  localparam int unsigned GDIO_STRB_W       = 4;

  // Register byte offsets, one aligned word each
  localparam logic [4:0]  GDIO_OFS_LATCH     = 5'h00;
  localparam logic [4:0]  GDIO_OFS_DIR       = 5'h04;
  localparam logic [4:0]  GDIO_OFS_INPUT     = 5'h08;
  localparam logic [4:0]  GDIO_OFS_CTRL      = 5'h0C;
  localparam logic [4:0]  GDIO_OFS_DIR_SET   = 5'h10;
  localparam logic [4:0]  GDIO_OFS_DIR_CLR   = 5'h14;
  localparam logic [4:0]  GDIO_OFS_LATCH_SET = 5'h18;
  localparam logic [4:0]  GDIO_OFS_LATCH_CLR = 5'h1C;

  // Control register field positions
  localparam int unsigned GDIO_CTRL_PUD_BIT   = 0;
  localparam int unsigned GDIO_CTRL_CLAMP_BIT = 1;

  // Values after reset
  localparam logic        GDIO_RST_DIR_BIT   = 1'b0;
  localparam logic        GDIO_RST_LATCH_BIT = 1'b0;
  localparam logic        GDIO_RST_PUD       = 1'b0;

  // Cycles from a latch write to its level in the input register
  localparam int unsigned GDIO_READBACK_CYCLES = 1;

  // Bus response codes
  localparam logic [1:0]  GDIO_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  GDIO_RESP_SLVERR   = 2'h2;

  // Register selected by an address
  typedef enum logic [3:0] {
    GDIO_REG_LATCH,
    GDIO_REG_DIR,
    GDIO_REG_INPUT,
    GDIO_REG_CTRL,
    GDIO_REG_DIR_SET,
    GDIO_REG_DIR_CLR,
    GDIO_REG_LATCH_SET,
    GDIO_REG_LATCH_CLR,
    GDIO_REG_NONE
  } gdio_reg_t;

  // Address decode shared by the write and read paths
  function automatic gdio_reg_t gdio_decode(input logic [GDIO_ADDR_W-1:0] addr);
    gdio_reg_t sel;
    sel = GDIO_REG_NONE;
    case (addr)
      GDIO_OFS_LATCH:     sel = GDIO_REG_LATCH;
      GDIO_OFS_DIR:       sel = GDIO_REG_DIR;
      GDIO_OFS_INPUT:     sel = GDIO_REG_INPUT;
      GDIO_OFS_CTRL:      sel = GDIO_REG_CTRL;
      GDIO_OFS_DIR_SET:   sel = GDIO_REG_DIR_SET;
      GDIO_OFS_DIR_CLR:   sel = GDIO_REG_DIR_CLR;
      GDIO_OFS_LATCH_SET: sel = GDIO_REG_LATCH_SET;
      GDIO_OFS_LATCH_CLR: sel = GDIO_REG_LATCH_CLR;
      default:            sel = GDIO_REG_NONE;
    endcase
    return sel;
  endfunction

endpackage

// ### testbench/gdio_port_assertions.sv
`timescale 1ns/100ps

module gdio_port_assertions #(
  parameter int unsigned PIN_COUNT = 8
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // Bus handshakes
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  // Pin controls
  input wire logic [PIN_COUNT-1:0] gpio_pin_out,
  input wire logic [PIN_COUNT-1:0] gpio_pin_oe,
  input wire logic [PIN_COUNT-1:0] gpio_pin_pullup
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////
  // Reset must hold pads released even without bus traffic
  property p_rst_tri; disable iff (1'b0) rst |-> gpio_pin_oe == '0 && gpio_pin_pullup == '0;
  endproperty
  a_rst_tri: assert property (p_rst_tri) else $error("pins not released in reset");
  property p_pu_in; (gpio_pin_pullup & (gpio_pin_oe | ~gpio_pin_out)) == '0; endproperty
  a_pu_in: assert property (p_pu_in) else $error("pull-up on wrong pin");
  // Pin controls move only together with a write response
  property p_pin_move; !$stable(gpio_pin_oe) || !$stable(gpio_pin_out) |-> $rose(s_axi_bvalid);
  endproperty
  a_pin_move: assert property (p_pin_move) else $error("pins moved without write");
  property p_wr_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_narrow; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  a_r_narrow: assert property (p_r_narrow) else $error("upper read bits set");
endmodule

bind gdio_port gdio_port_assertions #(.PIN_COUNT(PIN_COUNT)) u_gdio_port_assertions (
  .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .gpio_pin_out(gpio_pin_out), .gpio_pin_oe(gpio_pin_oe),
  .gpio_pin_pullup(gpio_pin_pullup));

// ### testbench/gdio_pad_model.sv
`timescale 1ns/100ps

module gdio_pad_model #(
  parameter int unsigned PIN_COUNT = 8
) (
  // Clock for floating pads
  input wire logic                 clk,
  // Port drive
  input wire logic [PIN_COUNT-1:0] pin_out,
  input wire logic [PIN_COUNT-1:0] pin_oe,
  input wire logic [PIN_COUNT-1:0] pin_pullup,
  // Outside source
  input wire logic [PIN_COUNT-1:0] ext_en,
  input wire logic [PIN_COUNT-1:0] ext_val,
  // Resolved level
  output logic [PIN_COUNT-1:0]     pad
);
  logic [PIN_COUNT-1:0] float_pat = '0;

  ////////////////////////////////////////////////////////////////
  // Floating pads wander, so no stale level reads right by luck
  always @(posedge clk) begin
    float_pat <= ~float_pat;
  end

  // Port driver first, then pull-up, then the outside source
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (pin_oe[i]) pad[i] = pin_out[i];
      else if (pin_pullup[i]) pad[i] = 1'b1;
      else if (ext_en[i]) pad[i] = ext_val[i];
      else pad[i] = float_pat[i];
    end
  end
endmodule

// ### testbench/tb_general_digital_io_port.sv
`timescale 1ns/100ps

module tb_general_digital_io_port;
  import gdio_pkg::*;
  logic clk, rst, ce, deep_sleep, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb;
  logic [7:0] ext_int_enable, pad, pin_out, pin_oe, pin_pu, ext_en, ext_val, v, m;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int error_cnt = 0;
  int n_tests = 0;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  gdio_port u_gdio_port (.clk(clk), .rst(rst), .ce(ce), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .deep_sleep(deep_sleep), .ext_int_enable(ext_int_enable), .gpio_pin_in(pad),
    .gpio_pin_out(pin_out), .gpio_pin_oe(pin_oe), .gpio_pin_pullup(pin_pu));
  gdio_pad_model u_gdio_pad_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pu), .ext_en(ext_en), .ext_val(ext_val), .pad(pad));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One write; trailing edge keeps a gap before the next request
  task automatic axw(input logic [4:0] a, input logic [7:0] d, input logic [1:0] e = 2'h0);
    bq.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] e = 2'h0);
    rq.push_back({e, 24'h0, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  // Monitor: oldest note against each response
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end

  initial begin
    #400000;
    error_cnt++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    {rst, ce, deep_sleep, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'b110000;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {ext_int_enable, ext_en, ext_val} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(81840));
    repeat (6) @(posedge clk);
    chk({pin_oe, pin_pu}, 34'h0);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    axr(GDIO_OFS_LATCH, 8'h00);
    axr(GDIO_OFS_DIR, 8'h00);
    $display("test reset done");
    v = $urandom;
    m = $urandom;
    axw(GDIO_OFS_LATCH, v);
    axw(GDIO_OFS_DIR, m);
    chk(pin_oe, m);
    chk(pin_out, v);
    chk(pin_pu, ~m & v);
    axr(GDIO_OFS_DIR, m);
    axw(GDIO_OFS_DIR, 8'hFF);
    v = $urandom;
    axw(GDIO_OFS_LATCH, v);
    axr(GDIO_OFS_INPUT, v);
    m = $urandom;
    axw(GDIO_OFS_INPUT, m);
    chk(pin_out, v ^ m);
    axw(GDIO_OFS_DIR_CLR, 8'h0F);
    axw(GDIO_OFS_DIR_SET, 8'h03);
    chk(pin_oe, 8'hF3);
    axw(GDIO_OFS_LATCH_SET, 8'h80);
    axw(GDIO_OFS_LATCH_CLR, 8'h01);
    axr(GDIO_OFS_LATCH, ((v ^ m) | 8'h80) & 8'hFE);
    $display("test drive done");
    // Output high to tri-state by way of pull-up input
    axw(GDIO_OFS_LATCH, 8'hFF);
    axw(GDIO_OFS_DIR, 8'h00);
    chk(pin_pu, 8'hFF);
    axr(GDIO_OFS_INPUT, 8'hFF);
    axw(GDIO_OFS_CTRL, 8'h01);
    chk(pin_pu, 8'h00);
    axw(GDIO_OFS_CTRL, 8'h00);
    axw(GDIO_OFS_LATCH, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      ext_en <= 8'hFF;
      ext_val <= v;
      repeat (2) @(posedge clk);
      axr(GDIO_OFS_INPUT, v);
    end
    $display("test pull-up and input done");
    deep_sleep <= 1'b1;
    ext_int_enable <= 8'h3C;
    ext_val <= 8'hFF;
    repeat (2) @(posedge clk);
    axr(GDIO_OFS_INPUT, 8'h3C);
    axr(GDIO_OFS_CTRL, 8'h02);
    deep_sleep <= 1'b0;
    axr(5'h03, 8'h00, GDIO_RESP_SLVERR);
    axw(5'h02, 8'hFF, GDIO_RESP_SLVERR);
    s_axi_wstrb <= 4'h0;
    axw(GDIO_OFS_LATCH, 8'hFF);
    s_axi_wstrb <= 4'hF;
    axr(GDIO_OFS_LATCH, 8'h00);
    axw(GDIO_OFS_DIR, 8'hFF);
    rst <= 1'b1;
    @(posedge clk);
    chk(pin_oe, 8'h00);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    axr(GDIO_OFS_DIR, 8'h00);
    $display("test sleep, error and reset done");
    close_out();
  end
endmodule
